// [inc/sat_pkg.sv]
package sat_pkg;

   // ****************************************
   // bus and data widths
   // ****************************************
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int REG_W  = 8;
   localparam int SMP_W  = 16;
   localparam int CH_W   = 4;
   localparam int EXP_W  = 3;
   localparam int SUM_W  = SMP_W + 7;
   localparam int NUM_UNITS = 2;

   // ****************************************
   // register indices, byte address is four times the index
   // ****************************************
   localparam logic [ADDR_W-1:0] IDX_SEQ_DIV      = 12'h031;
   localparam logic [ADDR_W-1:0] IDX_SEQ_PERIOD   = 12'h033;
   localparam logic [ADDR_W-1:0] IDX_FIRST_SAMPLE = 12'h042;
   localparam logic [ADDR_W-1:0] IDX_TIA_SECOND   = 12'h043;
   localparam logic [ADDR_W-1:0] IDX_TIA_THIRD    = 12'h044;
   localparam logic [ADDR_W-1:0] IDX_SUBS_RATIO   = 12'h045;
   localparam logic [ADDR_W-1:0] IDX_SEQ_CONFIG   = 12'h046;
   localparam logic [ADDR_W-1:0] IDX_ERR_FLAGS    = 12'h047;
   localparam logic [ADDR_W-1:0] IDX_AVG_SEL      = 12'h048;
   localparam logic [ADDR_W-1:0] IDX_AVG_EXP      = 12'h049;
   localparam logic [ADDR_W-1:0] IDX_DECIM_SEL    = 12'h04A;
   localparam logic [ADDR_W-1:0] IDX_DECIM_RATIO1 = 12'h04B;
   localparam logic [ADDR_W-1:0] IDX_DECIM_RATIO2 = 12'h04C;
   localparam logic [ADDR_W-1:0] IDX_PERIOD_TICKS = 12'h060;
   localparam logic [ADDR_W-1:0] IDX_SEQ_STEPS    = 12'h061;
   localparam logic [ADDR_W-1:0] IDX_SKIP_COUNT   = 12'h062;
   localparam int IDX_SHIFT = 2;

   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int SKIP_EVERY_PERIOD_BIT = 0;
   localparam int TIMING_ERR_BIT        = 7;
   localparam int UNIT2_SEL_LSB         = 4;
   localparam int UNIT2_EXP_LSB         = 4;
   localparam logic [REG_W-1:0] REG_RESET = 8'h00;
   localparam logic [REG_W-1:0] CFG_MASK  = 8'h01;
   localparam logic [REG_W-1:0] EXP_MASK  = 8'h77;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_PS  = 4000;
   localparam int TIME_UNIT_US   = 1;
   localparam int CYCLES_PER_US  = (TIME_UNIT_US * 1000000) / CLK_PERIOD_PS;
   localparam int PRESCALE_W     = 8;
   localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = PRESCALE_W'(CYCLES_PER_US - 1);

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic [CH_W-1:0]  chan;
      logic [SMP_W-1:0] data;
   } sat_sample_type;

   typedef struct packed {
      logic             valid;
      logic [SMP_W-1:0] data;
   } sat_avg_type;

   typedef enum logic [1:0] {
      COEF_ZERO = 2'b00,
      COEF_POS  = 2'b01,
      COEF_NEG  = 2'b11
   } sat_coef_type;

   typedef enum logic [1:0] {
      SQ_IDLE,
      SQ_RUN
   } sat_state_type;

endpackage

// [logic/sat_trigger_ctrl.sv]
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - non-zero second TIA time starts an extra conversion there, only on TIA
// - non-TIA channels get at most one conversion per period
// - third TIA time acts like the second, placed later, no overlap
// - ratio N gives N periods without conversion then one with; 0 converts always
// - skip-every-period bit applies the ratio to every period
// - with bit clear only the first period of an ADC cycle repeats
// - ADC cycle spans lowest-channel sequence through highest-channel sequence
// - start during conversion sets sticky error bit 7, writing 1 to bit 7 clears it
// - current period tick count readable, 8 bits
// - current sequence count readable, 8 bits
// - current skip count readable, 8 bits
// - two averaging units, channel picked by a nibble each
// - each unit averages 2^n samples, n from a 3-bit field
// - two decimation units, channel picked by a nibble each
// - decimated channel runs at cycle rate over ratio plus one
// - demodulator works only while the sequencer runs
// - demodulator coefficient is +1, 0 or -1 from timing windows
// - first conversion of a period starts at the first-sample time
// - period is period value times divider plus one microseconds
module sat_trigger_ctrl
   import sat_pkg::*;
(
   input  wire logic                 i_clk,
   input  wire logic                 i_rst,
   input  wire logic                 i_psel,
   input  wire logic                 i_penable,
   input  wire logic                 i_pwrite,
   input  wire logic [ADDR_W-1:0]    i_paddr,
   input  wire logic [DATA_W-1:0]    i_pwdata,
   output logic      [DATA_W-1:0]    o_prdata,
   output logic                      o_pready,
   output logic                      o_pslverr,
   input  wire logic                 i_seq_run,
   input  wire logic [CH_W-1:0]      i_adc_sel,
   input  wire logic [CH_W-1:0]      i_tia_channel,
   input  wire logic [CH_W-1:0]      i_lowest_channel,
   input  wire logic [CH_W-1:0]      i_highest_channel,
   input  wire logic                 i_adc_busy,
   input  wire logic                 i_manual_start,
   input  wire sat_sample_type       i_sample,
   input  wire logic                 i_sample_valid,
   input  wire logic                 i_demod_enable,
   input  wire logic                 i_pos_window,
   input  wire logic                 i_neg_window,
   output logic                      o_adc_start,
   output logic                      o_period_end,
   output sat_avg_type               o_avg1,
   output sat_avg_type               o_avg2,
   output sat_coef_type              o_demod_coef
);

   // ****************************************
   // registers
   // ****************************************
   logic [REG_W-1:0]      seq_div;
   logic [REG_W-1:0]      seq_period;
   logic [REG_W-1:0]      first_sample_cycle;
   logic [REG_W-1:0]      tia_second_sample_cycle;
   logic [REG_W-1:0]      tia_third_sample_cycle;
   logic [REG_W-1:0]      skip_ratio;
   logic [REG_W-1:0]      sequencer_config;
   logic                  timing_error;
   logic [REG_W-1:0]      average_channel_select;
   logic [REG_W-1:0]      average_count_exponent;
   logic [REG_W-1:0]      decimate_channel_select;
   logic [REG_W-1:0]      decim_unit1_ratio;
   logic [REG_W-1:0]      decim_unit2_ratio;

   // ****************************************
   // sequencer state
   // ****************************************
   sat_state_type         state;
   logic [PRESCALE_W-1:0] prescale;
   logic [REG_W-1:0]      div_count;
   logic [REG_W-1:0]      period_tick_count;
   logic [REG_W-1:0]      sequence_step_count;
   logic [REG_W-1:0]      skip_period_count;
   logic                  period_converts;
   logic [REG_W-1:0]      decim_count [NUM_UNITS];
   logic                  adc_start;

   // ****************************************
   // bus decode
   // ****************************************
   wire                   bus_setup  = i_psel & ~i_penable;
   wire                   bus_write  = i_psel & i_penable & i_pwrite;
   wire [ADDR_W-1:0]      reg_index  = i_paddr >> IDX_SHIFT;
   wire                   addr_align = (i_paddr[IDX_SHIFT-1:0] == 2'h0);
   wire [REG_W-1:0]       wdata      = i_pwdata[REG_W-1:0];
   wire                   wr_div     = bus_write & addr_align & (reg_index == IDX_SEQ_DIV);
   wire                   wr_period  = bus_write & addr_align & (reg_index == IDX_SEQ_PERIOD);
   wire                   wr_first   = bus_write & addr_align & (reg_index == IDX_FIRST_SAMPLE);
   wire                   wr_second  = bus_write & addr_align & (reg_index == IDX_TIA_SECOND);
   wire                   wr_third   = bus_write & addr_align & (reg_index == IDX_TIA_THIRD);
   wire                   wr_subs    = bus_write & addr_align & (reg_index == IDX_SUBS_RATIO);
   wire                   wr_cfg     = bus_write & addr_align & (reg_index == IDX_SEQ_CONFIG);
   wire                   wr_err     = bus_write & addr_align & (reg_index == IDX_ERR_FLAGS);
   wire                   wr_avg_sel = bus_write & addr_align & (reg_index == IDX_AVG_SEL);
   wire                   wr_avg_exp = bus_write & addr_align & (reg_index == IDX_AVG_EXP);
   wire                   wr_dec_sel = bus_write & addr_align & (reg_index == IDX_DECIM_SEL);
   wire                   wr_dec1    = bus_write & addr_align & (reg_index == IDX_DECIM_RATIO1);
   wire                   wr_dec2    = bus_write & addr_align & (reg_index == IDX_DECIM_RATIO2);

   logic [REG_W-1:0]      read_value;
   logic                  read_hit;

   always_comb begin
      read_hit   = addr_align;
      read_value = REG_RESET;
      unique case (reg_index)
         IDX_SEQ_DIV:      read_value = seq_div;
         IDX_SEQ_PERIOD:   read_value = seq_period;
         IDX_FIRST_SAMPLE: read_value = first_sample_cycle;
         IDX_TIA_SECOND:   read_value = tia_second_sample_cycle;
         IDX_TIA_THIRD:    read_value = tia_third_sample_cycle;
         IDX_SUBS_RATIO:   read_value = skip_ratio;
         IDX_SEQ_CONFIG:   read_value = sequencer_config;
         IDX_ERR_FLAGS:    read_value = {timing_error, 7'h00};
         IDX_AVG_SEL:      read_value = average_channel_select;
         IDX_AVG_EXP:      read_value = average_count_exponent;
         IDX_DECIM_SEL:    read_value = decimate_channel_select;
         IDX_DECIM_RATIO1: read_value = decim_unit1_ratio;
         IDX_DECIM_RATIO2: read_value = decim_unit2_ratio;
         IDX_PERIOD_TICKS: read_value = period_tick_count;
         IDX_SEQ_STEPS:    read_value = sequence_step_count;
         IDX_SKIP_COUNT:   read_value = skip_period_count;
         default:          read_hit   = 1'b0;
      endcase
   end

   assign o_pready = 1'b1;

   // ****************************************
   // bus read data and error, captured in setup
   // ****************************************
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_prdata  <= '0;
         o_pslverr <= 1'b0;
      end else if (bus_setup) begin
         o_prdata  <= {{(DATA_W-REG_W){1'b0}}, read_value};
         o_pslverr <= ~read_hit;
      end
   end

   // ****************************************
   // writable registers
   // ****************************************
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         seq_div                 <= REG_RESET;
         seq_period              <= REG_RESET;
         first_sample_cycle      <= REG_RESET;
         tia_second_sample_cycle <= REG_RESET;
         tia_third_sample_cycle  <= REG_RESET;
         skip_ratio              <= REG_RESET;
         sequencer_config        <= REG_RESET;
         average_channel_select  <= REG_RESET;
         average_count_exponent  <= REG_RESET;
         decimate_channel_select <= REG_RESET;
         decim_unit1_ratio       <= REG_RESET;
         decim_unit2_ratio       <= REG_RESET;
      end else begin
         if (wr_div)     seq_div                 <= wdata;
         if (wr_period)  seq_period              <= wdata;
         if (wr_first)   first_sample_cycle      <= wdata;
         if (wr_second)  tia_second_sample_cycle <= wdata;
         if (wr_third)   tia_third_sample_cycle  <= wdata;
         if (wr_subs)    skip_ratio              <= wdata;
         if (wr_cfg)     sequencer_config        <= wdata & CFG_MASK;
         if (wr_avg_sel) average_channel_select  <= wdata;
         if (wr_avg_exp) average_count_exponent  <= wdata & EXP_MASK;
         if (wr_dec_sel) decimate_channel_select <= wdata;
         if (wr_dec1)    decim_unit1_ratio       <= wdata;
         if (wr_dec2)    decim_unit2_ratio       <= wdata;
      end
   end

   // ****************************************
   // timing error flag, set wins over clear
   // ****************************************
   wire err_clear = wr_err & wdata[TIMING_ERR_BIT];
   wire any_start = adc_start | i_manual_start;
   wire err_set   = any_start & i_adc_busy;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         timing_error <= 1'b0;
      end else if (err_set) begin
         timing_error <= 1'b1;
      end else if (err_clear) begin
         timing_error <= 1'b0;
      end
   end

   // ****************************************
   // period timebase
   // ****************************************
   wire running     = (state == SQ_RUN);
   wire run_begin   = i_seq_run & ~running;
   wire us_tick     = running & (prescale == PRESCALE_LAST);
   wire cycle_tick  = us_tick & (div_count == seq_div);
   wire [REG_W-1:0] period_last = (seq_period == REG_RESET) ? REG_RESET : seq_period - 8'h01;
   wire period_done = cycle_tick & (period_tick_count == period_last);

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state <= SQ_IDLE;
      end else begin
         unique case (state)
            SQ_IDLE: if (i_seq_run)  state <= SQ_RUN;
            SQ_RUN:  if (!i_seq_run) state <= SQ_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst || !running) begin
         prescale <= '0;
         div_count <= REG_RESET;
      end else if (us_tick) begin
         prescale  <= '0;
         div_count <= (div_count == seq_div) ? REG_RESET : div_count + 8'h01;
      end else begin
         prescale <= prescale + 8'h01;
      end
   end

   // ****************************************
   // period, sequence and skip counters
   // ****************************************
   wire at_cycle_first = (i_adc_sel == i_lowest_channel);
   wire at_cycle_last  = (i_adc_sel == i_highest_channel);
   wire skip_every     = sequencer_config[SKIP_EVERY_PERIOD_BIT];
   wire skip_applies   = skip_every | at_cycle_first;
   wire skip_now       = skip_applies & (skip_period_count < skip_ratio);

   always_ff @(posedge i_clk) begin
      if (i_rst || run_begin) begin
         period_tick_count   <= REG_RESET;
         sequence_step_count <= REG_RESET;
         skip_period_count   <= REG_RESET;
      end else if (period_done) begin
         period_tick_count <= REG_RESET;
         if (skip_now) begin
            skip_period_count <= skip_period_count + 8'h01;
         end else begin
            skip_period_count   <= REG_RESET;
            sequence_step_count <= sequence_step_count + 8'h01;
         end
      end else if (cycle_tick) begin
         period_tick_count <= period_tick_count + 8'h01;
      end
   end

   // ****************************************
   // decimation units
   // ****************************************
   logic [NUM_UNITS-1:0] decim_block;
   wire  [REG_W-1:0]     decim_ratio [NUM_UNITS];
   assign decim_ratio[0] = decim_unit1_ratio;
   assign decim_ratio[1] = decim_unit2_ratio;

   for (genvar u = 0; u < NUM_UNITS; u++) begin : g_decim
      wire [CH_W-1:0] decim_chan = decimate_channel_select[u*UNIT2_SEL_LSB +: CH_W];
      wire            cycle_end  = period_done & ~skip_now & at_cycle_last;
      assign decim_block[u] = (i_adc_sel == decim_chan) & (decim_count[u] != REG_RESET);
      always_ff @(posedge i_clk) begin
         if (i_rst || run_begin) begin
            decim_count[u] <= REG_RESET;
         end else if (cycle_end) begin
            decim_count[u] <= (decim_count[u] >= decim_ratio[u]) ? REG_RESET : decim_count[u] + 8'h01;
         end
      end
   end

   // ****************************************
   // conversion starts
   // ****************************************
   wire on_tia      = (i_adc_sel == i_tia_channel);
   wire hit_first   = (period_tick_count == first_sample_cycle);
   wire hit_second  = on_tia & (tia_second_sample_cycle != REG_RESET) &
                      (period_tick_count == tia_second_sample_cycle);
   wire hit_third   = on_tia & (tia_third_sample_cycle != REG_RESET) &
                      (period_tick_count == tia_third_sample_cycle);
   wire convert_ok  = ~skip_now & ~(|decim_block);
   wire single_ok   = on_tia | ~period_converts;

   // only one start per period for non-TIA channels
   always_comb begin
      adc_start = cycle_tick & convert_ok & single_ok & (hit_first | hit_second | hit_third);
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_adc_start     <= 1'b0;
         o_period_end    <= 1'b0;
         period_converts <= 1'b0;
      end else begin
         o_adc_start     <= adc_start;
         o_period_end    <= period_done;
         period_converts <= period_done ? 1'b0 : (period_converts | adc_start);
      end
   end

   // ****************************************
   // averaging units
   // ****************************************
   logic [SUM_W-1:0] avg_sum   [NUM_UNITS];
   logic [7:0]       avg_count [NUM_UNITS];
   sat_avg_type      avg_out   [NUM_UNITS];

   for (genvar u = 0; u < NUM_UNITS; u++) begin : g_avg
      wire [CH_W-1:0]  avg_chan = average_channel_select[u*UNIT2_SEL_LSB +: CH_W];
      wire [EXP_W-1:0] avg_exp  = average_count_exponent[u*UNIT2_EXP_LSB +: EXP_W];
      wire             take     = i_sample_valid & (i_sample.chan == avg_chan);
      wire [7:0]       target   = 8'h01 << avg_exp;
      wire [SUM_W-1:0] new_sum  = avg_sum[u] + SUM_W'(i_sample.data);
      wire [7:0]       next_cnt = avg_count[u] + 8'h01;
      wire             complete = take & (next_cnt >= target);
      always_ff @(posedge i_clk) begin
         if (i_rst) begin
            avg_sum[u]   <= '0;
            avg_count[u] <= 8'h00;
            avg_out[u]   <= '0;
         end else begin
            avg_out[u].valid <= complete;
            if (complete) begin
               avg_out[u].data <= SMP_W'(new_sum >> avg_exp);
               avg_sum[u]      <= '0;
               avg_count[u]    <= 8'h00;
            end else if (take) begin
               avg_sum[u]   <= new_sum;
               avg_count[u] <= next_cnt;
            end
         end
      end
   end

   assign o_avg1 = avg_out[0];
   assign o_avg2 = avg_out[1];

   // ****************************************
   // demodulator coefficient
   // ****************************************
   always_ff @(posedge i_clk) begin
      if (i_rst || !running || !i_demod_enable) begin
         o_demod_coef <= COEF_ZERO;
      end else if (i_pos_window && !i_neg_window) begin
         o_demod_coef <= COEF_POS;
      end else if (i_neg_window && !i_pos_window) begin
         o_demod_coef <= COEF_NEG;
      end else begin
         o_demod_coef <= COEF_ZERO;
      end
   end

endmodule

`default_nettype wire

// [tb/sat_trigger_ctrl_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// ****
// port checker
// ****
module sat_chk
   import sat_pkg::*;
(
   input wire logic              i_clk,
   input wire logic              i_rst,
   input wire logic              i_psel,
   input wire logic              i_penable,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [DATA_W-1:0] o_prdata,
   input wire logic              o_pready,
   input wire logic              o_pslverr,
   input wire logic              i_seq_run,
   input wire logic              i_sample_valid,
   input wire logic              i_demod_enable,
   input wire logic              i_pos_window,
   input wire logic              i_neg_window,
   input wire logic              o_adc_start,
   input wire logic              o_period_end,
   input wire sat_avg_type       o_avg1,
   input wire sat_avg_type       o_avg2,
   input wire sat_coef_type      o_demod_coef
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   pready_high_a: assert property (o_pready) else $error("pready low");
   rdata_upper_a: assert property (o_prdata[31:8] == 24'h0) else $error("upper read bits set");
   unaligned_err_a: assert property (i_psel && !i_penable && i_paddr[1:0] != 2'b00 |=> o_pslverr)
      else $error("unaligned not refused");
   start_pulse_a: assert property (o_adc_start |=> !o_adc_start) else $error("start too long");
   period_gap_a: assert property (o_period_end |=> !o_period_end [*8]) else $error("period too short");
   start_run_a: assert property (!i_seq_run [*3] |-> !o_adc_start) else $error("start while idle");
   coef_gate_a: assert property (o_demod_coef != COEF_ZERO |-> $past(i_demod_enable) && $past(i_seq_run, 2))
      else $error("coef without run");
   coef_pos_a: assert property (i_demod_enable && $past(i_seq_run) && i_pos_window && !i_neg_window
      |=> o_demod_coef == COEF_POS) else $error("coef not plus");
   coef_neg_a: assert property (i_demod_enable && $past(i_seq_run) && i_neg_window && !i_pos_window
      |=> o_demod_coef == COEF_NEG) else $error("coef not minus");
   avg_cause_a: assert property (o_avg1.valid || o_avg2.valid |-> $past(i_sample_valid))
      else $error("average without sample");
   cover property (o_avg1.valid);
   cover property (o_avg2.valid);
   cover property (o_adc_start ##1 !o_adc_start);
endmodule
bind sat_trigger_ctrl sat_chk chk_i (.*);
`default_nettype wire

// [tb/sat_adc_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****
// adc with channel mux
// ****
module sat_adc_model
   import sat_pkg::*;
#(
   parameter int CONV = 20
)
(
   input wire logic            i_clk,
   input wire logic            i_rst,
   input wire logic            i_start,
   input wire logic            i_period_end,
   input wire logic [CH_W-1:0] i_lo,
   input wire logic [CH_W-1:0] i_hi,
   output logic                o_busy,
   output logic [CH_W-1:0]     o_sel,
   output sat_sample_type      o_sample,
   output logic                o_valid
);
   int               cnt;
   logic [SMP_W-1:0] pat;
   assign o_busy = (cnt != 0);
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt <= 0;
         o_sel <= i_lo;
         o_valid <= 1'b0;
         o_sample <= '0;
         pat <= 16'h1234;
      end else begin
         o_valid <= 1'b0;
         o_sample.data <= ~o_sample.data;
         if (i_period_end) begin
            o_sel <= (o_sel >= i_hi) ? i_lo : o_sel + 4'h1;
         end
         if (i_start) begin
            cnt <= CONV;
         end else if (cnt != 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
               o_valid <= 1'b1;
               o_sample <= {o_sel, pat};
               pat <= pat + 16'h1357;
            end
         end
      end
   end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top import sat_pkg::*;;
   logic i_clk, i_rst, psel, penable, pwrite, seq_run, man, dem, posw, negw, pready, pslverr, e, busy, sv, ast, pe;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, r;
   logic [CH_W-1:0]   sel;
   sat_sample_type    smp;
   sat_avg_type       a1, a2;
   sat_avg_type       av [2];
   sat_coef_type      coef;
   int seed = 13478, fail_count = 0, checks = 0, cyc = 0;
   logic [SUM_W-1:0] acc [2] = '{23'h0, 23'h0};
   int cnt [2] = '{0, 0};
   int aexp [2] = '{2, 1};
   logic [CH_W-1:0] asel [2] = '{4'h1, 4'h2};
   logic pend [2] = '{1'b0, 1'b0};
   logic [SMP_W-1:0] expd [2];
   localparam logic [ADDR_W-1:0] IDX_T [16] = '{IDX_SEQ_DIV, IDX_SEQ_PERIOD, IDX_FIRST_SAMPLE, IDX_TIA_SECOND,
      IDX_TIA_THIRD, IDX_SUBS_RATIO, IDX_SEQ_CONFIG, IDX_ERR_FLAGS, IDX_AVG_SEL, IDX_AVG_EXP, IDX_DECIM_SEL,
      IDX_DECIM_RATIO1, IDX_DECIM_RATIO2, IDX_PERIOD_TICKS, IDX_SEQ_STEPS, IDX_SKIP_COUNT};
   localparam logic [7:0] MASK_T [16] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, CFG_MASK, 8'h00, 8'hFF,
      EXP_MASK, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
   sat_trigger_ctrl dut (.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_seq_run(seq_run), .i_adc_sel(sel), .i_tia_channel(4'h1), .i_lowest_channel(4'h0),
      .i_highest_channel(4'h2), .i_adc_busy(busy), .i_manual_start(man), .i_sample(smp), .i_sample_valid(sv),
      .i_demod_enable(dem), .i_pos_window(posw), .i_neg_window(negw), .o_adc_start(ast), .o_period_end(pe),
      .o_avg1(a1), .o_avg2(a2), .o_demod_coef(coef));
   sat_adc_model adc (.i_clk(i_clk), .i_rst(i_rst), .i_start(ast | man), .i_period_end(pe), .i_lo(4'h0),
      .i_hi(4'h2), .o_busy(busy), .o_sel(sel), .o_sample(smp), .o_valid(sv));
   assign av[0] = a1;
   assign av[1] = a2;
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      posw <= cyc[2];
      negw <= cyc[3];
      for (int u = 0; u < 2; u++) begin
         if (pend[u]) chk(32'(av[u]), {15'h0, 1'b1, expd[u]});
         pend[u] = 1'b0;
         if (!i_rst && sv === 1'b1 && smp.chan === asel[u]) begin
            acc[u] = acc[u] + SUM_W'(smp.data);
            cnt[u]++;
            if (cnt[u] == (1 << aexp[u])) begin
               expd[u] = SMP_W'(acc[u] >> aexp[u]);
               pend[u] = 1'b1;
               acc[u] = '0;
               cnt[u] = 0;
            end
         end
      end
   end
   function automatic int tia_expect(input int cycles, input int dr);
      return cycles * 4 + cycles / (dr + 1);
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      checks++;
      if (g !== x) begin
         fail_count++;
         $display("ERROR %0t got %0h exp %0h", $time, g, x);
      end
   endtask
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge i_clk);
      penable <= 1'b1;
      do @(posedge i_clk);
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic wr(input logic [ADDR_W-1:0] i, input logic [7:0] d);
      apb(1'b1, i << IDX_SHIFT, d);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] i, input logic [7:0] x);
      apb(1'b0, i << IDX_SHIFT, 8'h00);
      chk(r, {24'h0, x});
   endtask
   task automatic wait_pe();
      do @(posedge i_clk);
      while (pe !== 1'b1);
   endtask
   task automatic count(input int np, output int n);
      int seen;
      n = 0;
      seen = 0;
      while (seen < np) begin
         @(posedge i_clk);
         if (ast === 1'b1) n++;
         if (pe === 1'b1) seen++;
      end
   endtask
   task automatic close_out();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #400000;
      fail_count++;
      $display("ERROR %0t watchdog", $time);
      close_out();
   end
   initial begin
      logic [7:0] d;
      int n, t;
      {i_rst, psel, penable, pwrite, seq_run, man, dem} = 7'h40;
      paddr = '0;
      pwdata = '0;
      repeat (20) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      for (int i = 0; i < 16; i++) rd(IDX_T[i], 8'h00);
      for (int i = 0; i < 16; i++) begin
         d = 8'($random(seed));
         wr(IDX_T[i], d);
         rd(IDX_T[i], d & MASK_T[i]);
      end
      apb(1'b0, 12'h140, 8'h00);
      chk({r[31:1], e}, 32'h1);
      apb(1'b0, (IDX_TIA_SECOND << IDX_SHIFT) | 12'h001, 8'h00);
      chk({31'h0, e}, 32'h1);
      wr(IDX_SEQ_DIV, 8'h00);
      wr(IDX_SEQ_PERIOD, 8'h05);
      wr(IDX_FIRST_SAMPLE, 8'h01);
      wr(IDX_TIA_SECOND, 8'h02);
      wr(IDX_TIA_THIRD, 8'h03);
      wr(IDX_SUBS_RATIO, 8'h00);
      wr(IDX_SEQ_CONFIG, 8'h00);
      wr(IDX_AVG_SEL, 8'h21);
      wr(IDX_AVG_EXP, 8'h12);
      wr(IDX_DECIM_SEL, 8'hF0);
      wr(IDX_DECIM_RATIO1, 8'h01);
      wr(IDX_DECIM_RATIO2, 8'h00);
      wr(IDX_ERR_FLAGS, 8'h80);
      man <= 1'b1;
      @(posedge i_clk);
      man <= 1'b0;
      repeat (4) @(posedge i_clk);
      man <= 1'b1;
      @(posedge i_clk);
      man <= 1'b0;
      repeat (30) @(posedge i_clk);
      rd(IDX_ERR_FLAGS, 8'h80);
      wr(IDX_ERR_FLAGS, 8'h80);
      rd(IDX_ERR_FLAGS, 8'h00);
      seq_run <= 1'b1;
      dem <= 1'b1;
      wait_pe();
      t = cyc;
      wait_pe();
      chk(cyc - t, 5 * CYCLES_PER_US);
      count(6, n);
      chk(n, tia_expect(2, 1));
      rd(IDX_ERR_FLAGS, 8'h00);
      wr(IDX_TIA_SECOND, 8'h00);
      wr(IDX_TIA_THIRD, 8'h00);
      wr(IDX_DECIM_SEL, 8'hFF);
      wr(IDX_SEQ_CONFIG, 8'h01);
      for (int k = 0; k < 3; k++) begin
         wr(IDX_SUBS_RATIO, 8'(k));
         wait_pe();
         wait_pe();
         count(6, n);
         chk(n, 6 / (k + 1));
      end
      close_out();
   end
endmodule
`default_nettype wire
